//--- rtl/camc_mode_ctrl.sv
`timescale 1ns/1ps
// Operation
// R1: idle suspend bit freezes counter during idle
// R2: watchdog enable makes module five watchdog
// R3: lock keeps watchdog enabled until reset
// R4: bit four reads zero, writes ignored
// R5: timebase select picks counter clock source
// R6: count input falls no faster than clock/4
// R7: external clock divided by eight, synchronized
// R8: overflow flag requests interrupt when enabled
// R9: watchdog enabled blocks writes to other fields
// R10: reset enables watchdog, other bits zero
// R11: wrap to zero sets sticky overflow flag
// R12: reserved timebase codes give no pulses
module camc_mode_ctrl (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] sfrAddr,
  input wire logic [7:0] sfrWrData,
  input wire logic sfrWrEn,
  input wire logic sfrRdEn,
  output logic [7:0] sfrRdData,
  input wire logic runEnable,
  input wire logic cpuIdle,
  input wire logic timer0Ovf,
  input wire logic externalCountInput,
  input wire logic extClkIn,
  input wire logic overflowClear,
  output logic [camc_pkg::CAMC_CNT_W-1:0] counterValue,
  output logic counterOverflowFlag,
  output logic irqReq,
  output logic watchdogActive
);
  import camc_pkg::*;

  logic idleSuspendSelect; // freeze in idle
  logic watchdogEnable; // module five runs as watchdog
  logic watchdogLock; // enable locked until reset
  logic [2:0] timebaseSelect; // counter clock source
  logic overflowIrqEnable; // overflow interrupt mask
  logic wrHit; // write to the mode register
  logic rdHit; // read of the mode register
  logic countEn; // counter advances this cycle
  logic [7:0] modeView; // register as read back

  camc_tb_if tbLink();

  assign wrHit = sfrWrEn && (sfrAddr == CAMC_MODE_ADDR);
  assign rdHit = sfrRdEn && (sfrAddr == CAMC_MODE_ADDR);
  assign tbLink.timebaseSelect = timebaseSelect;
  assign tbLink.freeze = cpuIdle && idleSuspendSelect; // R1
  assign countEn = tbLink.countPulse && runEnable && !tbLink.freeze; // R1

  // pulse generator for the chosen timebase
  camc_timebase u_timebase (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .timer0Ovf(timer0Ovf),
    .externalCountInput(externalCountInput),
    .extClkIn(extClkIn),
    .tb(tbLink.gen)
  );

  // mode fields, writable only with the watchdog off
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      idleSuspendSelect <= CAMC_MODE_RESET[CAMC_IDLE_BIT]; // R10
      timebaseSelect <= CAMC_MODE_RESET[CAMC_SEL_HI:CAMC_SEL_LO]; // R10
      overflowIrqEnable <= CAMC_MODE_RESET[CAMC_OVIE_BIT]; // R10
    end else if (wrHit && !watchdogEnable) begin // R9
      idleSuspendSelect <= sfrWrData[CAMC_IDLE_BIT];
      timebaseSelect <= sfrWrData[CAMC_SEL_HI:CAMC_SEL_LO]; // R5
      overflowIrqEnable <= sfrWrData[CAMC_OVIE_BIT];
    end
  end

  // watchdog enable and lock; setting lock also enables
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      watchdogEnable <= CAMC_MODE_RESET[CAMC_WDEN_BIT]; // R10
      watchdogLock <= CAMC_MODE_RESET[CAMC_WDLK_BIT]; // R10
    end else if (wrHit) begin
      // lock is sticky until reset
      watchdogLock <= watchdogLock || sfrWrData[CAMC_WDLK_BIT]; // R3
      // a clear is ignored once locked
      watchdogEnable <= sfrWrData[CAMC_WDEN_BIT] ||
                        sfrWrData[CAMC_WDLK_BIT] || watchdogLock; // R3 R2
    end
  end

  // watchdog mode to capture/compare module five
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      watchdogActive <= 1'b0;
    end else begin
      watchdogActive <= watchdogEnable; // R2
    end
  end

  // read view with the unused bit tied low
  always_comb begin
    modeView = 8'h00;
    modeView[CAMC_IDLE_BIT] = idleSuspendSelect;
    modeView[CAMC_WDEN_BIT] = watchdogEnable;
    modeView[CAMC_WDLK_BIT] = watchdogLock;
    modeView[CAMC_UNUSED_BIT] = 1'b0; // R4
    modeView[CAMC_SEL_HI:CAMC_SEL_LO] = timebaseSelect;
    modeView[CAMC_OVIE_BIT] = overflowIrqEnable;
  end

  // read data registered, zero on other addresses
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sfrRdData <= 8'h00;
    end else if (rdHit) begin
      sfrRdData <= modeView; // R4
    end else begin
      sfrRdData <= 8'h00;
    end
  end

  // 16-bit counter advanced by count pulses
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      counterValue <= CAMC_CNT_ZERO;
    end else if (countEn) begin
      counterValue <= counterValue + 16'h0001;
    end
  end

  // overflow flag; a wrap in the clear cycle wins
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      counterOverflowFlag <= 1'b0;
    end else if (countEn && counterValue == CAMC_CNT_MAX) begin
      counterOverflowFlag <= 1'b1; // R11
    end else if (overflowClear) begin
      counterOverflowFlag <= 1'b0;
    end
  end

  // interrupt request gated by the overflow mask
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irqReq <= 1'b0;
    end else begin
      irqReq <= counterOverflowFlag && overflowIrqEnable; // R8
    end
  end

  // rule checks on the register, watchdog and counter
  a_idle_freeze_hold: assert property ( // R1
    @(posedge core_clk) disable iff (!rst_n)
    cpuIdle && idleSuspendSelect |=> $stable(counterValue))
    else $error("counter moved while idle suspended");
  // freeze also stops the pulse path itself
  a_freeze_no_pulse: assert property ( // R1
    @(posedge core_clk) disable iff (!rst_n)
    tbLink.freeze |=> !tbLink.countPulse)
    else $error("count pulse while frozen");
  // active output lags enable by one clock once out of reset
  a_wd_active_follow: assert property ( // R2
    @(posedge core_clk) disable iff (!rst_n)
    $past(rst_n) |-> watchdogActive == $past(watchdogEnable))
    else $error("watchdog active does not follow enable");
  a_wd_lock_holds: assert property ( // R3
    @(posedge core_clk) disable iff (!rst_n)
    watchdogLock |=> watchdogLock && watchdogEnable)
    else $error("locked watchdog was disabled");
  // writing the lock bit enables and locks at once
  a_lock_sets_enable: assert property ( // R3
    @(posedge core_clk) disable iff (!rst_n)
    wrHit && sfrWrData[CAMC_WDLK_BIT] |=> watchdogLock && watchdogEnable)
    else $error("lock write did not lock the watchdog");
  // without the lock a zero write turns the watchdog off
  a_wd_unlocked_clear: assert property ( // R3
    @(posedge core_clk) disable iff (!rst_n)
    wrHit && !watchdogLock && !sfrWrData[CAMC_WDEN_BIT] &&
      !sfrWrData[CAMC_WDLK_BIT] |=> !watchdogEnable)
    else $error("unlocked watchdog could not be disabled");
  a_unused_bit_zero: assert property ( // R4
    @(posedge core_clk) disable iff (!rst_n)
    rdHit |=> sfrRdData[CAMC_UNUSED_BIT] == 1'b0)
    else $error("unused bit read as one");
  a_irq_mask_gate: assert property ( // R8
    @(posedge core_clk) disable iff (!rst_n)
    irqReq == $past(counterOverflowFlag && overflowIrqEnable))
    else $error("interrupt request does not follow flag and mask");
  // a masked flag never reaches the request line
  a_irq_needs_mask: assert property ( // R8
    @(posedge core_clk) disable iff (!rst_n)
    !overflowIrqEnable |=> !irqReq)
    else $error("interrupt request with overflow masked");
  a_wd_fields_frozen: assert property ( // R9
    @(posedge core_clk) disable iff (!rst_n)
    wrHit && watchdogEnable |=> $stable(timebaseSelect) &&
      $stable(idleSuspendSelect) && $stable(overflowIrqEnable))
    else $error("mode field changed while watchdog enabled");
  a_wrap_sets_flag: assert property ( // R11
    @(posedge core_clk) disable iff (!rst_n)
    countEn && counterValue == CAMC_CNT_MAX |=>
      counterOverflowFlag && counterValue == CAMC_CNT_ZERO)
    else $error("wrap did not set overflow flag");
  a_flag_sticky: assert property ( // R11
    @(posedge core_clk) disable iff (!rst_n)
    counterOverflowFlag && !overflowClear |=> counterOverflowFlag)
    else $error("overflow flag dropped without clear");
  // a clear with no wrap in that cycle drops the flag
  a_flag_clear_works: assert property ( // R11
    @(posedge core_clk) disable iff (!rst_n)
    overflowClear && !(countEn && counterValue == CAMC_CNT_MAX) |=>
      !counterOverflowFlag)
    else $error("overflow flag survived a clear");
  a_reset_values: assert property ( // R10
    @(posedge core_clk)
    !rst_n |=> !rst_n || (watchdogEnable && !watchdogLock &&
      timebaseSelect == CAMC_TB_SYS12))
    else $error("wrong state after reset");

  // covers for the main scenarios
  c_overflow_irq: cover property (@(posedge core_clk) disable iff (!rst_n)
    counterOverflowFlag && overflowIrqEnable ##1 irqReq);
  c_wd_disabled: cover property (@(posedge core_clk) disable iff (!rst_n)
    $fell(watchdogEnable));
  c_blocked_write: cover property (@(posedge core_clk) disable iff (!rst_n)
    wrHit && watchdogEnable && sfrWrData[CAMC_SEL_HI:CAMC_SEL_LO] != 3'h0);
  c_locked_clear: cover property (@(posedge core_clk) disable iff (!rst_n)
    wrHit && watchdogLock && !sfrWrData[CAMC_WDEN_BIT]);
endmodule

//--- rtl/camc_pkg.sv
// shared constants for the counter array mode control block
package camc_pkg;
  // register offset on the special function register bus
  localparam logic [7:0] CAMC_MODE_ADDR = 8'hD9;
  // field positions inside counter_mode_control
  localparam int CAMC_IDLE_BIT = 7;
  localparam int CAMC_WDEN_BIT = 6;
  localparam int CAMC_WDLK_BIT = 5;
  localparam int CAMC_UNUSED_BIT = 4;
  localparam int CAMC_SEL_HI = 3;
  localparam int CAMC_SEL_LO = 1;
  localparam int CAMC_OVIE_BIT = 0;
  // reset value: watchdog enabled, all else clear
  localparam logic [7:0] CAMC_MODE_RESET = 8'h40;
  // timebase select codes
  typedef enum logic [2:0] {
    CAMC_TB_SYS12 = 3'h0,
    CAMC_TB_SYS4 = 3'h1,
    CAMC_TB_T0OVF = 3'h2,
    CAMC_TB_ECI = 3'h3,
    CAMC_TB_SYS = 3'h4,
    CAMC_TB_EXT8 = 3'h5
  } camc_tbsel_e;
  // reserved code prefix in the upper two select bits
  localparam logic [1:0] CAMC_TB_RSVD_HI = 2'h3;
  // divider terminal counts
  localparam logic [3:0] CAMC_DIV12_LAST = 4'hB;
  localparam logic [1:0] CAMC_DIV4_LAST = 2'h3;
  localparam logic [2:0] CAMC_EXT8_LAST = 3'h7;
  // counter width and limits
  localparam int CAMC_CNT_W = 16;
  localparam logic [15:0] CAMC_CNT_MAX = 16'hFFFF;
  localparam logic [15:0] CAMC_CNT_ZERO = 16'h0000;
endpackage

//--- rtl/camc_tb_if.sv
`timescale 1ns/1ps
// carries timebase control to the pulse generator and pulses back
interface camc_tb_if;
  logic [2:0] timebaseSelect; // current timebase code
  logic freeze; // idle suspend in force
  logic countPulse; // one-cycle count advance
  modport ctrl (output timebaseSelect, output freeze, input countPulse);
  modport gen (input timebaseSelect, input freeze, output countPulse);
endinterface

//--- rtl/camc_timebase.sv
`timescale 1ns/1ps
// produces one-cycle count pulses from the selected timebase
module camc_timebase (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic timer0Ovf,
  input wire logic externalCountInput,
  input wire logic extClkIn,
  camc_tb_if.gen tb
);
  import camc_pkg::*;
  logic [3:0] div12; // system clock divide by 12
  logic [1:0] div4; // system clock divide by 4
  logic [2:0] ext8; // external clock rising edge counter
  logic eciPrev; // last count input level
  logic extPrev; // last external clock level
  logic next_pulse; // pulse before the output flop
  logic extRise; // rising edge of the external clock

  assign extRise = extClkIn && !extPrev;

  // edge history, kept running so no stale edge shows after idle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      eciPrev <= 1'b1;
      extPrev <= 1'b0;
    end else begin
      eciPrev <= externalCountInput;
      extPrev <= extClkIn;
    end
  end

  // prescalers halt while frozen
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      div12 <= 4'h0;
      div4 <= 2'h0;
      ext8 <= 3'h0;
    end else if (!tb.freeze) begin
      div12 <= (div12 == CAMC_DIV12_LAST) ? 4'h0 : div12 + 4'h1;
      div4 <= div4 + 2'h1;
      // external clock counted in system clock domain
      if (extRise) begin // R7
        ext8 <= ext8 + 3'h1;
      end
    end
  end

  // source selection
  always_comb begin
    case (tb.timebaseSelect)
      CAMC_TB_SYS12: next_pulse = (div12 == CAMC_DIV12_LAST); // R5
      CAMC_TB_SYS4: next_pulse = (div4 == CAMC_DIV4_LAST); // R5
      CAMC_TB_T0OVF: next_pulse = timer0Ovf; // R5
      // falling edge; source must stay at or below clock/4
      CAMC_TB_ECI: next_pulse = eciPrev && !externalCountInput; // R5 R6
      CAMC_TB_SYS: next_pulse = 1'b1; // R5
      CAMC_TB_EXT8: next_pulse = extRise && (ext8 == CAMC_EXT8_LAST); // R7
      default: next_pulse = 1'b0; // R12
    endcase
  end

  // registered pulse, blocked during freeze
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tb.countPulse <= 1'b0;
    end else begin
      tb.countPulse <= next_pulse && !tb.freeze; // R1
    end
  end

  a_reserved_no_pulse: assert property ( // R12
    @(posedge core_clk) disable iff (!rst_n)
    tb.timebaseSelect[2:1] == CAMC_TB_RSVD_HI |=> !tb.countPulse)
    else $error("pulse from reserved timebase");
  a_sysclk_every_cycle: assert property ( // R5
    @(posedge core_clk) disable iff (!rst_n)
    tb.timebaseSelect == CAMC_TB_SYS && !tb.freeze |=> tb.countPulse)
    else $error("system clock timebase missed a pulse");
  c_ext_div_pulse: cover property (@(posedge core_clk) disable iff (!rst_n)
    tb.timebaseSelect == CAMC_TB_EXT8 ##1 tb.countPulse);
endmodule

//--- tb/camc_src_model.sv
`timescale 1ns/1ps
// far-side event sources: timer 0 overflow, count pin, external clock
module camc_src_model (
  input wire logic core_clk,
  output logic timer0Ovf,
  output logic externalCountInput,
  output logic extClkIn
);
  // idle levels: no pulse, count pin pulled high, clock low
  initial begin
    timer0Ovf = 1'b0;
    externalCountInput = 1'b1;
    extClkIn = 1'b0;
  end
  // one-cycle timer 0 overflow pulses with gaps between them
  task automatic t0Pulses(input int n);
    repeat (n) begin
      @(posedge core_clk) timer0Ovf <= 1'b1;
      @(posedge core_clk) timer0Ovf <= 1'b0;
      repeat (3) @(posedge core_clk);
    end
  endtask
  // count pin falls, never closer together than four clocks
  task automatic eciFalls(input int n);
    repeat (n) begin
      @(posedge core_clk) externalCountInput <= 1'b0;
      repeat (3) @(posedge core_clk);
      externalCountInput <= 1'b1;
      repeat (3) @(posedge core_clk);
    end
  endtask
  // external clock rising edges, period of six core clocks
  task automatic extEdges(input int n);
    repeat (n) begin
      @(posedge core_clk) extClkIn <= 1'b1;
      repeat (3) @(posedge core_clk);
      extClkIn <= 1'b0;
      repeat (2) @(posedge core_clk);
    end
  endtask
endmodule

//--- tb/tb_camc_mode_ctrl.sv
`timescale 1ns/1ps
// self-checking bench for the counter array mode control block
module tb_camc_mode_ctrl;
  import camc_pkg::*;
  logic core_clk, rst_n, sfrWrEn, sfrRdEn, runEnable, cpuIdle;
  logic overflowClear, timer0Ovf, externalCountInput, extClkIn;
  logic [7:0] sfrAddr, sfrWrData, sfrRdData;
  logic [15:0] counterValue, base;
  logic counterOverflowFlag, irqReq, watchdogActive;
  int err_count, checked, i;
  // device under test
  camc_mode_ctrl u_camc_mode_ctrl (.core_clk(core_clk), .rst_n(rst_n),
    .sfrAddr(sfrAddr), .sfrWrData(sfrWrData), .sfrWrEn(sfrWrEn),
    .sfrRdEn(sfrRdEn), .sfrRdData(sfrRdData), .runEnable(runEnable),
    .cpuIdle(cpuIdle), .timer0Ovf(timer0Ovf),
    .externalCountInput(externalCountInput), .extClkIn(extClkIn),
    .overflowClear(overflowClear), .counterValue(counterValue),
    .counterOverflowFlag(counterOverflowFlag), .irqReq(irqReq),
    .watchdogActive(watchdogActive));
  // event sources on the far side
  camc_src_model u_camc_src_model (.core_clk(core_clk),
    .timer0Ovf(timer0Ovf), .externalCountInput(externalCountInput),
    .extClkIn(extClkIn));
  // 100 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // compare and count
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // verdict and end of run
  task automatic give_verdict();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // one-cycle write strobe, taken at the following edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk) begin
      sfrWrEn <= 1'b1;
      sfrAddr <= a;
      sfrWrData <= d;
    end
    @(posedge core_clk) sfrWrEn <= 1'b0;
    #1;
  endtask
  // one-cycle read strobe, data stands the cycle after
  task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk) begin
      sfrRdEn <= 1'b1;
      sfrAddr <= a;
    end
    @(posedge core_clk) sfrRdEn <= 1'b0;
    #1 check("sfrRdData", {8'h00, sfrRdData}, {8'h00, exp});
  endtask
  // set mode, let stale pulses drain, then snapshot the counter
  task automatic setMode(input logic [7:0] m);
    wr(CAMC_MODE_ADDR, m);
    repeat (4) @(posedge core_clk);
    #1 base = counterValue;
  endtask
  // count advance over a fixed window of clocks
  task automatic span(input logic [7:0] m, input logic [15:0] exp);
    setMode(m);
    repeat (24) @(posedge core_clk);
    #1 check("count", counterValue - base, exp);
  endtask
  // hang guard
  initial begin
    repeat (90000) @(posedge core_clk);
    err_count++;
    give_verdict();
  end
  // main sequence
  initial begin
    {rst_n, sfrWrEn, sfrRdEn, runEnable, cpuIdle, overflowClear} = 6'h00;
    sfrAddr = 8'h00;
    sfrWrData = 8'h00;
    err_count = 0;
    checked = 0;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    runEnable <= 1'b1;
    rdChk(CAMC_MODE_ADDR, CAMC_MODE_RESET);
    check("wdActive", watchdogActive, 1'b1);
    wr(CAMC_MODE_ADDR, 8'hCF);
    rdChk(CAMC_MODE_ADDR, 8'h40);
    wr(CAMC_MODE_ADDR, 8'h00);
    rdChk(CAMC_MODE_ADDR, 8'h00);
    #20 check("wdActive", watchdogActive, 1'b0);
    rdChk(8'hD8, 8'h00); // unmapped address reads zero
    wr(CAMC_MODE_ADDR, 8'h1E);
    rdChk(CAMC_MODE_ADDR, 8'h0E);
    span(8'h00, 16'h2);
    span(8'h02, 16'h6);
    span(8'h08, 16'h18);
    span(8'h0C, 16'h0);
    span(8'h0E, 16'h0);
    setMode(8'h04);
    u_camc_src_model.t0Pulses(3);
    repeat (4) @(posedge core_clk);
    #1 check("t0 count", counterValue - base, 16'h3);
    setMode(8'h06);
    u_camc_src_model.eciFalls(3);
    repeat (4) @(posedge core_clk);
    #1 check("eci count", counterValue - base, 16'h3);
    setMode(8'h0A);
    u_camc_src_model.extEdges(16);
    repeat (6) @(posedge core_clk);
    #1 check("ext8 count", counterValue - base, 16'h2);
    @(posedge core_clk) cpuIdle <= 1'b1;
    span(8'h88, 16'h0);
    span(8'h08, 16'h18);
    @(posedge core_clk) cpuIdle <= 1'b0;
    setMode(8'h09);
    i = 0;
    while (counterOverflowFlag !== 1'b1 && i < 70000) begin
      @(posedge core_clk);
      #1 i++;
    end
    check("wrap value", counterValue, CAMC_CNT_ZERO);
    @(posedge core_clk);
    #1 check("irq on", irqReq, 1'b1);
    wr(CAMC_MODE_ADDR, 8'h08);
    #20 check("irq masked", irqReq, 1'b0);
    check("flag sticky", counterOverflowFlag, 1'b1);
    @(posedge core_clk) overflowClear <= 1'b1;
    @(posedge core_clk) overflowClear <= 1'b0;
    #20 check("flag clear", counterOverflowFlag, 1'b0);
    wr(CAMC_MODE_ADDR, 8'h20);
    rdChk(CAMC_MODE_ADDR, 8'h60);
    wr(CAMC_MODE_ADDR, 8'h00);
    rdChk(CAMC_MODE_ADDR, 8'h60);
    check("wdActive", watchdogActive, 1'b1);
    @(posedge core_clk) rst_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    rdChk(CAMC_MODE_ADDR, CAMC_MODE_RESET);
    give_verdict();
  end
endmodule
